// ===== logic/air_codec_top.sv
`timescale 1ns/100ps
`include "air_codec_defines.svh"
module air_codec_top #(
  parameter logic [1:0] MEM_SIZE = `MEMSZ_2048  // Memory size code
) (
  input  wire logic       REF_CLK,        // System clock
  input  wire logic       RSTN,           // Async reset, low
  input  wire logic       CARRIER_IN,     // Carrier from antenna
  input  wire logic       FIELD_IN,       // Field present level
  output      logic       MOD_ON,         // Load modulator drive
  input  wire logic [7:0] NV_MODE_BYTE,   // Stored mode/lock byte
  input  wire logic [7:0] NV_PAGE_LOCK,   // Stored page-lock byte
  input  wire logic       CFG_WR,         // Config write strobe
  input  wire logic       CFG_SEL_PAGE,   // 1 page-lock, 0 mode byte
  input  wire logic [7:0] CFG_WDATA,      // Config write data
  output      logic       NV_WR_EN,       // Granted store write
  output      logic       NV_WR_SEL,      // Byte being stored
  output      logic [7:0] NV_WR_DATA,     // Value being stored
  output      logic [7:0] MEM_TYPE_BYTE,  // Memory-type byte
  output      logic [7:0] MODE_BYTE,      // Active mode/lock byte
  input  wire logic       IDREQ_VALID,    // Id request received
  input  wire logic [1:0] IDREQ_VARIANT,  // Id request variant
  input  wire logic       SELECT_MATCH,   // Select with own id
  input  wire logic       AUTH_OK,        // Challenge passed
  output      logic       SELECTED,       // Tag selected
  output      logic       TAG_FIRST,      // Tag-first streaming
  output      logic [5:0] STREAM_FIRST,   // First streamed page
  output      logic [5:0] STREAM_LAST,    // Last streamed page
  output      logic       RACE_STD,       // Racing variant on
  output      logic       SECRET_WR_OK,   // Secret pages writable
  output      logic       SECRET_RD_OK,   // Secret pages readable
  input  wire logic       TX_VALID,       // Reply bit offered
  input  wire logic       TX_BIT,         // Reply bit value
  output      logic       TX_READY,       // Reply bit taken
  output      logic       RX_VALID,       // Received bit pulse
  output      logic       RX_BIT,         // Received bit value
  output      logic       RX_EOF,         // End of frame pulse
  output      logic       RX_ERR          // Gap length error pulse
);
  logic                      car_s1_ff;
  logic                      car_s2_ff;
  logic                      car_d_ff;
  logic                      fld_s1_ff;
  logic                      fld_s2_ff;
  logic                      fld_d_ff;
  logic                      tick;
  logic                      gap_fall;
  logic                      gap_rise;
  logic                      eof_hit;
  logic [5:0]                gap_cnt_ff;
  logic [5:0]                hi_cnt_ff;
  logic [5:0]                ivl_cnt_ff;
  logic                      in_frame_ff;
  air_codec_pkg::rx_sym_s    rx_ff;
  logic                      load_ff;
  air_codec_pkg::mode_lock_s mode_ff;
  air_codec_pkg::mode_lock_s nv_mode;
  air_codec_pkg::mode_lock_s wr_mode;
  air_codec_pkg::mem_type_s  mem_type_ff;
  logic                      wr_en_ff;
  logic                      wr_sel_ff;
  logic [7:0]                wr_data_ff;
  air_codec_pkg::tag_state_e state_ff;
  air_codec_pkg::coding_e    id_code_ff;
  air_codec_pkg::rate_e      id_rate_ff;
  air_codec_pkg::tx_cfg_s    tx_cfg;
  logic [5:0]                last_page;
  // Tag-first rate field decode
  function automatic air_codec_pkg::rate_e tf_rate(input logic [1:0] s);
    case (s)
      `RATE_SEL_8K: tf_rate = air_codec_pkg::RATE_8K;
      `RATE_SEL_4K: tf_rate = air_codec_pkg::RATE_4K;
      default:      tf_rate = air_codec_pkg::RATE_2K;
    endcase
  endfunction
  // ==========================================
  // Pin synchronisers
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      car_s1_ff <= 1'h0;
      car_s2_ff <= 1'h0;
      car_d_ff  <= 1'h0;
      fld_s1_ff <= 1'h1;
      fld_s2_ff <= 1'h1;
      fld_d_ff  <= 1'h1;
    end else begin
      car_s1_ff <= CARRIER_IN;
      car_s2_ff <= car_s1_ff;
      car_d_ff  <= car_s2_ff;
      fld_s1_ff <= FIELD_IN;
      fld_s2_ff <= fld_s1_ff;
      fld_d_ff  <= fld_s2_ff;
    end
  end
  // Carrier edge and field edges; off field is low
  assign tick     = car_s2_ff & ~car_d_ff;
  assign gap_fall = fld_d_ff & ~fld_s2_ff;
  assign gap_rise = ~fld_d_ff & fld_s2_ff;
  assign eof_hit  = in_frame_ff && fld_s2_ff && tick &&
                    hi_cnt_ff == `EOF_LEN;
  // ==========================================
  // Receiver: carrier-period counters
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      gap_cnt_ff <= 6'h00;
      hi_cnt_ff  <= 6'h00;
      ivl_cnt_ff <= 6'h00;
    end else begin
      if (gap_fall) begin
        gap_cnt_ff <= tick ? 6'h01 : 6'h00;
      end else if (!fld_s2_ff && tick && gap_cnt_ff != `CNT_MAX) begin
        gap_cnt_ff <= 6'(gap_cnt_ff + 6'h01);
      end
      if (gap_rise) begin
        hi_cnt_ff <= 6'h00;
      end else if (fld_s2_ff && tick && hi_cnt_ff != `CNT_MAX) begin
        hi_cnt_ff <= 6'(hi_cnt_ff + 6'h01);
      end
      if (gap_fall) begin
        ivl_cnt_ff <= 6'h00;
      end else if (tick && ivl_cnt_ff != `CNT_MAX) begin
        ivl_cnt_ff <= 6'(ivl_cnt_ff + 6'h01);
      end
    end
  end
  // Frame open from first gap until end of frame
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      in_frame_ff <= 1'h0;
    end else if (gap_fall) begin
      in_frame_ff <= 1'h1;
    end else if (eof_hit) begin
      in_frame_ff <= 1'h0;
    end
  end
  // Symbol decisions at each gap after the one that opens the frame
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_ff <= '0;
    end else begin
      rx_ff.valid <= gap_fall && in_frame_ff;
      rx_ff.value <= ivl_cnt_ff > `ZERO_ONE_SPLIT;
      rx_ff.eof   <= eof_hit;
      rx_ff.err   <= gap_rise && (gap_cnt_ff < `GAP_MIN ||
                                  gap_cnt_ff > `GAP_MAX);
    end
  end
  assign RX_VALID = rx_ff.valid;
  assign RX_BIT   = rx_ff.value;
  assign RX_EOF   = rx_ff.eof;
  assign RX_ERR   = rx_ff.err;
  // ==========================================
  // Configuration load after reset release
  assign nv_mode = air_codec_pkg::mode_lock_s'(NV_MODE_BYTE);
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      load_ff     <= 1'h1;
      mode_ff     <= '0;
      mem_type_ff <= '0;
    end else if (load_ff) begin
      load_ff     <= 1'h0;
      mode_ff     <= nv_mode;
      mem_type_ff <= {`SPARE_ZERO, MEM_SIZE};
    end
  end
  assign MODE_BYTE     = mode_ff;
  assign MEM_TYPE_BYTE = mem_type_ff;
  // Lock bit stays set once stored
  always_comb begin
    wr_mode             = air_codec_pkg::mode_lock_s'(CFG_WDATA);
    wr_mode.config_lock = wr_mode.config_lock | nv_mode.config_lock;
  end
  // Mode-byte writes refused under the active lock; page-lock writes always granted, set bits kept while the lock is active
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wr_en_ff   <= 1'h0;
      wr_sel_ff  <= 1'h0;
      wr_data_ff <= 8'h00;
    end else begin
      wr_en_ff  <= CFG_WR && (CFG_SEL_PAGE || !mode_ff.config_lock);
      wr_sel_ff <= CFG_SEL_PAGE;
      if (!CFG_SEL_PAGE) begin
        wr_data_ff <= wr_mode;
      end else if (mode_ff.config_lock) begin
        wr_data_ff <= NV_PAGE_LOCK | CFG_WDATA;
      end else begin
        wr_data_ff <= CFG_WDATA;
      end
    end
  end
  assign NV_WR_EN   = wr_en_ff;
  assign NV_WR_SEL  = wr_sel_ff;
  assign NV_WR_DATA = wr_data_ff;
  // Secret page access
  assign SECRET_WR_OK = !mode_ff.secret_lock;
  assign SECRET_RD_OK = !(mode_ff.secret_lock && mode_ff.auth);
  // ==========================================
  // Tag state
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_ff <= air_codec_pkg::ST_INIT;
    end else if (load_ff) begin
      state_ff <= (nv_mode.tag_first_page_sel == `PAGE_SEL_OFF) ?
                  air_codec_pkg::ST_INIT :
                  air_codec_pkg::ST_TAG_FIRST;
    end else begin
      case (state_ff)
        air_codec_pkg::ST_TAG_FIRST: begin
          if (IDREQ_VALID) begin
            state_ff <= air_codec_pkg::ST_INIT;
          end
        end
        air_codec_pkg::ST_INIT: begin
          if (SELECT_MATCH) begin
            state_ff <= mode_ff.auth ? air_codec_pkg::ST_CHALLENGE :
                        air_codec_pkg::ST_SELECTED;
          end
        end
        air_codec_pkg::ST_CHALLENGE: begin
          if (AUTH_OK) begin
            state_ff <= air_codec_pkg::ST_SELECTED;
          end
        end
        air_codec_pkg::ST_SELECTED: state_ff <= air_codec_pkg::ST_SELECTED;
        default: state_ff <= air_codec_pkg::ST_INIT;
      endcase
    end
  end
  // Reply coding and rate from the id request
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      id_code_ff <= air_codec_pkg::CODE_AC;
      id_rate_ff <= air_codec_pkg::RATE_2K;
    end else if (IDREQ_VALID) begin
      id_code_ff <= (IDREQ_VARIANT == `IDREQ_AC_2K ||
                     IDREQ_VARIANT == `IDREQ_AC_4K) ?
                    air_codec_pkg::CODE_AC :
                    air_codec_pkg::CODE_MC;
      id_rate_ff <= (IDREQ_VARIANT == `IDREQ_AC_2K) ? air_codec_pkg::RATE_2K :
                    (IDREQ_VARIANT == `IDREQ_MC_8K) ? air_codec_pkg::RATE_8K :
                    air_codec_pkg::RATE_4K;
    end
  end
  // Coder setting per state
  always_comb begin
    tx_cfg.coding = air_codec_pkg::CODE_MC;
    tx_cfg.rate   = id_rate_ff;
    case (state_ff)
      air_codec_pkg::ST_TAG_FIRST: begin
        tx_cfg.coding = mode_ff.tag_first_coding_sel ?
                        air_codec_pkg::CODE_BC :
                        air_codec_pkg::CODE_MC;
        tx_cfg.rate   = tf_rate(mode_ff.tag_first_rate_sel);
      end
      air_codec_pkg::ST_INIT: tx_cfg.coding = id_code_ff;
      default: begin
        if (id_rate_ff == air_codec_pkg::RATE_2K) begin
          tx_cfg.rate = air_codec_pkg::RATE_4K;
        end
      end
    endcase
  end
  // Last streamed page
  always_comb begin
    case (mode_ff.tag_first_page_sel)
      `PAGE_SEL_4_5: last_page = `STREAM_P5;
      `PAGE_SEL_4_7: last_page = `STREAM_P7;
      default:       last_page = `STREAM_P4;
    endcase
  end
  assign SELECTED     = state_ff == air_codec_pkg::ST_SELECTED;
  assign TAG_FIRST    = state_ff == air_codec_pkg::ST_TAG_FIRST;
  assign STREAM_FIRST = `STREAM_P4;
  assign STREAM_LAST  = last_page;
  assign RACE_STD     = mode_ff.tag_first_rate_sel == `RATE_SEL_2K_RACE;
  // ==========================================
  // Reply coder
  tx_bit_coder u_coder (
    .clk       (REF_CLK),
    .rst_n     (RSTN),
    .tick      (tick),
    .cfg       (tx_cfg),
    .bit_valid (TX_VALID),
    .bit_value (TX_BIT),
    .bit_ready (TX_READY),
    .mod_on    (MOD_ON)
  );
  // ==========================================
  // Checks
  a_cfg_lock_refuse: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    CFG_WR && !CFG_SEL_PAGE && mode_ff.config_lock |=> !NV_WR_EN)
    else $error("locked mode byte written");
  a_page_otp_keep: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    CFG_WR && CFG_SEL_PAGE && mode_ff.config_lock
    |=> (NV_WR_DATA & $past(NV_PAGE_LOCK)) == $past(NV_PAGE_LOCK))
    else $error("page lock bit cleared");
  a_cfg_hold: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    !load_ff |=> $stable(mode_ff))
    else $error("config changed before reset");
  a_auth_select: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    !load_ff && state_ff == air_codec_pkg::ST_INIT && SELECT_MATCH &&
    mode_ff.auth |=> state_ff == air_codec_pkg::ST_CHALLENGE)
    else $error("secure select skipped challenge");
  a_tf_rate: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    TAG_FIRST && mode_ff.tag_first_rate_sel == `RATE_SEL_8K
    |-> tx_cfg.rate == air_codec_pkg::RATE_8K)
    else $error("tag-first rate wrong");
  a_rx_zero: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    rx_ff.valid && !rx_ff.value |-> $past(ivl_cnt_ff) <= `ZERO_ONE_SPLIT)
    else $error("long interval taken as zero");
  a_eof_len: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    rx_ff.eof |-> $past(hi_cnt_ff) == `EOF_LEN && !in_frame_ff)
    else $error("end of frame at wrong length");
  a_mem_spare: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    !load_ff |-> MEM_TYPE_BYTE[7:2] == `SPARE_ZERO)
    else $error("spare memory-type bits set");
endmodule

// ===== logic/air_codec_defines.svh
`ifndef AIR_CODEC_DEFINES_SVH
`define AIR_CODEC_DEFINES_SVH
// ==========================================
// Bit lengths in carrier periods
`define BITLEN_2K        7'h40
`define BITLEN_4K        7'h20
`define BITLEN_8K        7'h10
// ==========================================
// Reader coding limits in carrier periods
`define GAP_MIN          6'h04
`define GAP_MAX          6'h0A
`define ZERO_ONE_SPLIT   6'h18
`define EOF_LEN          6'h24
`define CNT_MAX          6'h3F
// ==========================================
// Tag-first stream pages
`define STREAM_P4        6'h04
`define STREAM_P5        6'h05
`define STREAM_P7        6'h07
// ==========================================
// Field codes
`define MEMSZ_32         2'h0
`define MEMSZ_256        2'h1
`define MEMSZ_2048       2'h2
`define PAGE_SEL_OFF     2'h0
`define PAGE_SEL_4_5     2'h1
`define PAGE_SEL_4_7     2'h2
`define PAGE_SEL_4       2'h3
`define RATE_SEL_4K      2'h0
`define RATE_SEL_8K      2'h1
`define RATE_SEL_2K      2'h2
`define RATE_SEL_2K_RACE 2'h3
`define IDREQ_AC_2K      2'h0
`define IDREQ_AC_4K      2'h1
`define IDREQ_MC_4K      2'h2
`define IDREQ_MC_8K      2'h3
`define SPARE_ZERO       6'h00
`endif

// ===== logic/air_codec_pkg.sv
`include "air_codec_defines.svh"
package air_codec_pkg;
  typedef enum logic [1:0] {CODE_AC, CODE_MC, CODE_BC} coding_e;
  typedef enum logic [1:0] {RATE_2K, RATE_4K, RATE_8K} rate_e;
  typedef enum logic [1:0] {
    ST_INIT, ST_CHALLENGE, ST_SELECTED, ST_TAG_FIRST
  } tag_state_e;
  typedef struct packed {
    logic       auth;
    logic       tag_first_coding_sel;
    logic [1:0] tag_first_rate_sel;
    logic [1:0] tag_first_page_sel;
    logic       config_lock;
    logic       secret_lock;
  } mode_lock_s;
  typedef struct packed {
    logic [5:0] spare_bits;
    logic [1:0] memory_size_field;
  } mem_type_s;
  typedef struct packed {
    logic valid;
    logic value;
    logic eof;
    logic err;
  } rx_sym_s;
  typedef struct packed {
    coding_e coding;
    rate_e   rate;
  } tx_cfg_s;

  // Bit length in carrier periods for a rate
  function automatic logic [6:0] bit_len(input rate_e r);
    case (r)
      RATE_2K: bit_len = `BITLEN_2K;
      RATE_8K: bit_len = `BITLEN_8K;
      default: bit_len = `BITLEN_4K;
    endcase
  endfunction
endpackage

// ===== logic/tx_bit_coder.sv
`timescale 1ns/100ps
`include "air_codec_defines.svh"
module tx_bit_coder (
  input  wire logic                   clk,       // System clock
  input  wire logic                   rst_n,     // Async reset, low
  input  wire logic                   tick,      // One carrier period
  input  wire air_codec_pkg::tx_cfg_s cfg,       // Coding and rate
  input  wire logic                   bit_valid, // Bit offered
  input  wire logic                   bit_value, // Bit to send
  output      logic                   bit_ready, // Coder idle
  output      logic                   mod_on     // Load modulator drive
);
  logic                   busy_ff;
  logic [6:0]             cnt_ff;
  logic                   bit_ff;
  logic                   lvl_ff;
  logic                   mod_ff;
  air_codec_pkg::tx_cfg_s cfg_ff;
  logic [6:0]             len;
  logic [6:0]             half;
  logic [6:0]             qtr;
  logic [6:0]             tq;
  logic                   q_odd;
  logic                   take;
  logic                   nxt_mod;

  // ==========================================
  // Bit geometry
  assign len       = air_codec_pkg::bit_len(cfg_ff.rate);
  assign half      = len >> 1;
  assign qtr       = len >> 2;
  assign tq        = 7'(half + qtr);
  assign q_odd     = (cnt_ff >= qtr && cnt_ff < half) || cnt_ff >= tq;
  assign take      = bit_valid && !busy_ff;
  assign bit_ready = !busy_ff;
  assign mod_on    = mod_ff;

  // Bit framing counted in carrier periods
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'h0;
      cnt_ff  <= 7'h00;
      bit_ff  <= 1'h0;
      cfg_ff  <= '0;
    end else if (take) begin
      busy_ff <= 1'h1;
      cnt_ff  <= 7'h00;
      bit_ff  <= bit_value;
      cfg_ff  <= cfg;
    end else if (busy_ff && tick) begin
      if (cnt_ff == 7'(len - 7'h01)) begin
        busy_ff <= 1'h0;
      end
      cnt_ff <= 7'(cnt_ff + 7'h01);
    end
  end

  // Biphase line level flips at each bit start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_ff <= 1'h0;
    end else if (take) begin
      lvl_ff <= ~lvl_ff;
    end
  end

  // Coded level for the current position
  always_comb begin
    nxt_mod = 1'h0;
    if (busy_ff) begin
      case (cfg_ff.coding)
        air_codec_pkg::CODE_AC: nxt_mod = bit_ff ^ q_odd;
        air_codec_pkg::CODE_MC: nxt_mod = bit_ff ^ (cnt_ff >= half);
        air_codec_pkg::CODE_BC: nxt_mod = lvl_ff ^ (!bit_ff && cnt_ff >= half);
        default:                nxt_mod = 1'h0;
      endcase
    end
  end

  // High level loads the field
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mod_ff <= 1'h0;
    end else begin
      mod_ff <= nxt_mod;
    end
  end

  // ==========================================
  // Checks
  a_mod_idle_low: assert property (
    @(posedge clk) disable iff (!rst_n)
    !busy_ff && !take |=> ##1 !mod_on)
    else $error("modulator on while idle");
  a_bit_length: assert property (
    @(posedge clk) disable iff (!rst_n)
    busy_ff && tick && cnt_ff == 7'(len - 7'h01)
    |=> !busy_ff && cnt_ff == $past(len))
    else $error("bit length wrong");
  a_bp_toggle: assert property (
    @(posedge clk) disable iff (!rst_n)
    take |=> lvl_ff != $past(lvl_ff))
    else $error("biphase start did not toggle");
endmodule

// ===== bench/reader_model.sv
`timescale 1ns/100ps
// ==========================================
// Reader unit: carrier runs free, field keyed off and on
module reader_model (
  output logic carrier, // Carrier to the tag
  output logic field    // Field level, 0 = off
);
  // Carrier at 160 ns, field on while idle
  initial begin
    carrier = 1'b0;
    field = 1'b1;
    forever #80 carrier = ~carrier;
  end

  // Wait whole carrier periods
  task automatic wait_t0(input int n);
    repeat (n) @(posedge carrier);
  endtask

  // Frame of n bits, msb first, closed by end of frame
  task automatic send_frame(input logic [7:0] bits, input int n,
                            input int gap, input int t0, input int t1);
    wait_t0(1); // Gaps start on a carrier edge
    for (int i = n - 1; i >= -1; i--) begin
      field = 1'b0;
      wait_t0(gap);
      field = 1'b1;
      if (i < 0) wait_t0(40);
      else wait_t0((bits[i] ? t1 : t0) - gap);
    end
  endtask
endmodule

// ===== bench/tb_top.sv
`timescale 1ns/100ps
`include "air_codec_defines.svh"
// ==========================================
// Testbench top
module tb_top;
  logic       clk, rst_n, carrier, field, mod_on, cfg_wr, cfg_sel;
  logic       nv_wr_en, nv_wr_sel, idreq_valid, select_match, auth_ok;
  logic       selected, tag_first, race_std, secret_wr_ok, secret_rd_ok;
  logic       tx_valid, tx_bit, tx_ready, rx_valid, rx_bit, rx_eof, rx_err;
  logic [7:0] nv_mode, nv_page, cfg_wdata, nv_wr_data, mem_type, mode_byte;
  logic [7:0] rx_q, m;
  logic [5:0] first_pg, last_pg;
  logic [1:0] idreq_var;
  int         error_cnt, check_count, rx_n, eof_n, err_n, len;
  logic [7:0] tbl [5] = '{8'h00, 8'hB5, 8'h68, 8'h1D, 8'h04};

  reader_model rdr (.carrier(carrier), .field(field));

  air_codec_top DUT (
    .REF_CLK(clk), .RSTN(rst_n), .CARRIER_IN(carrier), .FIELD_IN(field),
    .MOD_ON(mod_on), .NV_MODE_BYTE(nv_mode), .NV_PAGE_LOCK(nv_page),
    .CFG_WR(cfg_wr), .CFG_SEL_PAGE(cfg_sel), .CFG_WDATA(cfg_wdata),
    .NV_WR_EN(nv_wr_en), .NV_WR_SEL(nv_wr_sel), .NV_WR_DATA(nv_wr_data),
    .MEM_TYPE_BYTE(mem_type), .MODE_BYTE(mode_byte),
    .IDREQ_VALID(idreq_valid), .IDREQ_VARIANT(idreq_var),
    .SELECT_MATCH(select_match), .AUTH_OK(auth_ok), .SELECTED(selected),
    .TAG_FIRST(tag_first), .STREAM_FIRST(first_pg), .STREAM_LAST(last_pg),
    .RACE_STD(race_std), .SECRET_WR_OK(secret_wr_ok),
    .SECRET_RD_OK(secret_rd_ok), .TX_VALID(tx_valid), .TX_BIT(tx_bit),
    .TX_READY(tx_ready), .RX_VALID(rx_valid), .RX_BIT(rx_bit),
    .RX_EOF(rx_eof), .RX_ERR(rx_err));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Receive monitor
  always @(posedge clk) begin
    if (rx_valid === 1'b1) begin
      rx_q = {rx_q[6:0], rx_bit};
      rx_n++;
    end
    if (rx_eof === 1'b1) eof_n++;
    if (rx_err === 1'b1) err_n++;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s seen %h expected %h",
               $time, msg, seen, exp);
    end
  endtask

  task automatic rst(input logic [7:0] mb);
    rst_n = 1'b0;
    nv_mode = mb;
    cyc(16);
    rst_n = 1'b1;
    cyc(3);
  endtask

  // One-cycle pulse on id request, select, challenge
  task automatic strobe(input logic [2:0] w);
    {idreq_valid, select_match, auth_ok} = w;
    cyc(1);
    {idreq_valid, select_match, auth_ok} = 3'h0;
    cyc(1);
  endtask

  task automatic cfg(input logic s, input logic [7:0] d,
                     input logic en, input logic [7:0] q);
    cfg_wr = 1'b1;
    cfg_sel = s;
    cfg_wdata = d;
    cyc(1);
    cfg_wr = 1'b0;
    check(nv_wr_en, en, "store grant");
    if (en) check({nv_wr_sel, nv_wr_data}, {s, q}, "store data");
    cyc(1);
  endtask

  // Reply bit: quarters sampled mid-way, then length
  task automatic send_bit(input logic b, input int n, input logic [3:0] pat);
    int c;
    c = 0;
    tx_bit = b;
    tx_valid = 1'b1;
    cyc(1);
    tx_valid = 1'b0;
    cyc(2);
    for (int q = 0; q < 4; q++) begin
      cyc(q == 0 ? n * 2 : n * 4);
      check(mod_on, pat[3 - q], "coded level");
    end
    while (tx_ready !== 1'b1 && c < 400) begin
      cyc(1);
      c++;
    end
    c = c + 14 * n + 1;
    check(c >= 16 * n - 20 && c <= 16 * n + 20, 1, "bit length");
    cyc(2);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test();
  end

  // Tests
  initial begin
    {rst_n, cfg_wr, cfg_sel, idreq_valid, select_match, auth_ok} = 6'h00;
    {tx_valid, tx_bit, idreq_var, cfg_wdata, nv_mode, nv_page} = 28'h0;
    {rx_q, rx_n, eof_n, err_n, error_cnt, check_count} = '0;
    for (int i = 0; i < 5; i++) begin
      m = tbl[i];
      rst(m);
      check(mem_type, {6'h00, `MEMSZ_2048}, "memory type");
      check(mode_byte, m, "mode byte");
      check(tag_first, m[3:2] != 2'h0, "tag first");
      check({first_pg, last_pg}, {6'h04, m[3:2] == 2'h1 ? 6'h05 :
            m[3:2] == 2'h2 ? 6'h07 : 6'h04}, "pages");
      check(race_std, m[5:4] == 2'h3, "race");
      check({secret_wr_ok, secret_rd_ok}, {!m[0], !(m[0] & m[7])},
            "secret");
      len = m[5:4] == 2'h0 ? 32 : m[5:4] == 2'h1 ? 16 : 64;
      if (m[3:2] != 2'h0) send_bit(!m[6], len, 4'hC);
    end
    $display("test configuration load done");
    for (int v = 0; v < 4; v++) begin
      idreq_var = v[1:0];
      strobe(3'h4);
      len = v == 0 ? 64 : v == 3 ? 16 : 32;
      send_bit(1'b1, len, v < 2 ? 4'hA : 4'hC);
      send_bit(1'b0, len, v < 2 ? 4'h5 : 4'h3);
    end
    $display("test reply coding done");
    strobe(3'h2);
    check(selected, 1'b1, "plain select");
    rst(8'h80);
    strobe(3'h2);
    check(selected, 1'b0, "secure select");
    strobe(3'h1);
    check(selected, 1'b1, "after challenge");
    $display("test selection done");
    rst(8'h00);
    cfg(1'b0, 8'h5A, 1'b1, 8'h5A);
    check(mode_byte, 8'h00, "mode held");
    nv_page = 8'h0F;
    rst(8'h02);
    cfg(1'b0, 8'h00, 1'b0, 8'h00);
    cfg(1'b1, 8'hF0, 1'b1, 8'hFF);
    $display("test configuration write done");
    rdr.send_frame(8'hA5, 8, 4, 18, 26);
    cyc(20);
    check({rx_q, 8'(rx_n), 8'(eof_n)}, 24'hA50801, "frame a");
    rdr.send_frame(8'h3C, 8, 10, 22, 30);
    cyc(20);
    check({rx_q, 8'(rx_n), 8'(eof_n)}, 24'h3C1002, "frame b");
    check(err_n, 0, "no gap error");
    rdr.send_frame(8'h01, 2, 2, 18, 26);
    cyc(20);
    check(err_n > 0, 1, "short gap");
    $display("test reader frames done");
    end_of_test();
  end
endmodule
